/* src/pwr_clk_cfg.svh */
// Purpose: offsets, field positions and reset values of the power and clock-output block
// Assumes: word index addressing on the plain register port
// Notes: definitions only
`ifndef PWR_CLK_CFG_SVH
`define PWR_CLK_CFG_SVH
`define ADDR_SYSCFG 4'h0
`define ADDR_XPERCFG 4'h1
`define ADDR_CLKDIV 4'h2
`define ADDR_MODECMD 4'h3
`define ADDR_STATUS 4'h4
`define SYSCFG_EXT_BUS_PERIPHERAL_ENABLE_BIT 2
`define SYSCFG_POWERDOWN_WAKE_CONFIG_BIT_BIT 5
`define SYSCFG_CLOCK_OUTPUT_ENABLE_BIT_BIT 6
`define XPERCFG_XMISC_BIT 10
`define XPERCFG_XRAM2_BIT 11
`define MODECMD_MODE_LSB 0
`define MODECMD_OPT_LSB 2
`define SYSCFG_RESET 16'h0000
`define XPERCFG_RESET 16'h0000
`define CLKDIV_RESET 16'h0000
`define MODECMD_RESET 16'h0000
`endif

/* src/pwr_clk_pkg.sv */
// Purpose: types shared by the power and clock-output block
// Assumes: nothing beyond the cfg header
// Notes: modes and control outputs of the power reduction states
package pwr_clk_pkg;
   typedef enum logic [1:0] {
      mode_run = 2'b00,
      mode_idle = 2'b01,
      mode_pdown = 2'b10,
      mode_standby = 2'b11
   } pwr_mode_t;
   typedef struct packed {
      logic cpu_clk_en;
      logic periph_clk_en;
      logic main_osc_en;
      logic osc32_en;
      logic rtc_en;
      logic rtc_from_osc32;
      logic stby_ram_bias;
      logic ram_bias;
      logic pdown_wake_en;
   } pwr_ctrl_t;
endpackage : pwr_clk_pkg

/* src/power_mode_and_clock_output_control.sv */
// Purpose: power mode gating and programmable prescaled clock output
// Assumes: plain register port, reads answer one cycle after the strobe
// Notes: reg 3 holds mode in bits 1:0 and option in bits 3:2
`timescale 1ns/100ps
`include "pwr_clk_cfg.svh"
module power_mode_and_clock_output_control #(
   parameter int DIV_W = 16
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   output pwr_clk_pkg::pwr_ctrl_t o_ctrl,
   output logic o_clock_output_port_pin,
   output logic o_clock_output_port_pin_oe_n
);
   logic [15:0] syscfg_q;
   logic [15:0] xpercfg_q;
   logic [DIV_W-1:0] clkdiv_q;
   logic [15:0] modecmd_q;
   logic [DIV_W-1:0] div_act_q;
   logic [DIV_W-1:0] cnt_q;
   logic half_q;
   logic clk_en;
   logic prescale_ok;
   pwr_clk_pkg::pwr_mode_t mode;
   logic [1:0] opt;
   pwr_clk_pkg::pwr_ctrl_t ctrl_d;

   assign clk_en = syscfg_q[`SYSCFG_CLOCK_OUTPUT_ENABLE_BIT_BIT];
   assign prescale_ok = syscfg_q[`SYSCFG_EXT_BUS_PERIPHERAL_ENABLE_BIT] & xpercfg_q[`XPERCFG_XMISC_BIT];
   assign mode = pwr_clk_pkg::pwr_mode_t'(modecmd_q[`MODECMD_MODE_LSB +: 2]);
   assign opt = modecmd_q[`MODECMD_OPT_LSB +: 2];

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         syscfg_q <= `SYSCFG_RESET;
         xpercfg_q <= `XPERCFG_RESET;
         clkdiv_q <= DIV_W'(`CLKDIV_RESET);
         modecmd_q <= `MODECMD_RESET;
      end else if (i_wr) begin
         case (i_addr)
            `ADDR_SYSCFG: syscfg_q <= i_wdata;
            `ADDR_XPERCFG: xpercfg_q <= i_wdata;
            `ADDR_CLKDIV: clkdiv_q <= i_wdata[DIV_W-1:0];
            `ADDR_MODECMD: modecmd_q <= i_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         case (i_addr)
            `ADDR_SYSCFG: o_rdata <= syscfg_q;
            `ADDR_XPERCFG: o_rdata <= xpercfg_q;
            `ADDR_CLKDIV: o_rdata <= 16'(clkdiv_q);
            `ADDR_MODECMD: o_rdata <= modecmd_q;
            `ADDR_STATUS: o_rdata <= {7'h00, o_ctrl};
            default: o_rdata <= 16'h0000;
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   always_comb begin
      ctrl_d = '1;
      ctrl_d.rtc_from_osc32 = 1'b1;
      ctrl_d.pdown_wake_en = 1'b0;
      case (mode)
         pwr_clk_pkg::mode_run: ;
         pwr_clk_pkg::mode_idle: begin
            ctrl_d.cpu_clk_en = 1'b0;
            ctrl_d.osc32_en = opt[0];
            ctrl_d.rtc_en = opt[0];
         end
         pwr_clk_pkg::mode_pdown: begin
            ctrl_d.cpu_clk_en = 1'b0;
            ctrl_d.periph_clk_en = 1'b0;
            ctrl_d.main_osc_en = (opt == 2'b01);
            ctrl_d.osc32_en = (opt == 2'b10);
            ctrl_d.rtc_en = (opt == 2'b01) | (opt == 2'b10);
            ctrl_d.rtc_from_osc32 = (opt == 2'b10);
            ctrl_d.pdown_wake_en = syscfg_q[`SYSCFG_POWERDOWN_WAKE_CONFIG_BIT_BIT];
         end
         pwr_clk_pkg::mode_standby: begin
            ctrl_d.cpu_clk_en = 1'b0;
            ctrl_d.periph_clk_en = 1'b0;
            ctrl_d.main_osc_en = 1'b0;
            ctrl_d.osc32_en = opt[0];
            ctrl_d.rtc_en = opt[0];
            ctrl_d.ram_bias = 1'b0;
         end
         default: ;
      endcase
      // idle and power-down leave both ram bias bits at one
      if (mode != pwr_clk_pkg::mode_standby) begin
         ctrl_d.ram_bias = 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_ctrl <= '1;
      end else begin
         o_ctrl <= ctrl_d;
      end
   end

   // divider: output toggles every div_act+1 cycles when prescaling
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         div_act_q <= '0;
         cnt_q <= '0;
         half_q <= 1'b0;
      end else if (!clk_en) begin
         cnt_q <= '0;
         half_q <= 1'b0;
         div_act_q <= prescale_ok ? clkdiv_q : '0;
      end else if (cnt_q >= div_act_q) begin
         cnt_q <= '0;
         half_q <= ~half_q;
         // only at end of a high half, so a whole period completes first
         if (half_q) begin
            div_act_q <= prescale_ok ? clkdiv_q : '0;
         end
      end else begin
         cnt_q <= cnt_q + DIV_W'(1);
      end
   end

   // undivided mode toggles every edge: half the core rate, the fastest a flop can make
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_clock_output_port_pin <= 1'b0;
         o_clock_output_port_pin_oe_n <= 1'b1;
      end else begin
         o_clock_output_port_pin <= clk_en & half_q;
         o_clock_output_port_pin_oe_n <= ~clk_en;
      end
   end
endmodule : power_mode_and_clock_output_control

/* testbench/pmc_chk.sv */
// Purpose: port checks of power mode and clock output
// Assumes: config index 0 holds the output enable
// Notes: mode checks use the o_ctrl pattern only
`timescale 1ns/100ps
module pmc_chk (
   input wire logic i_clock, i_rst, i_wr, i_rd,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata, o_rdata,
   input wire pwr_clk_pkg::pwr_ctrl_t o_ctrl,
   input wire logic o_clock_output_port_pin, o_clock_output_port_pin_oe_n
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   logic ck_q;
   wire cpu = o_ctrl.cpu_clk_en, per = o_ctrl.periph_clk_en, mo = o_ctrl.main_osc_en;
   wire o32 = o_ctrl.osc32_en, rtc = o_ctrl.rtc_en, sb = o_ctrl.stby_ram_bias, rb = o_ctrl.ram_bias;
   wire pin = o_clock_output_port_pin, oen = o_clock_output_port_pin_oe_n;
   always_ff @(posedge i_clock or posedge i_rst)
      if (i_rst) ck_q <= 1'h0;
      else if (i_wr && i_addr == 4'h0) ck_q <= i_wdata[6];
   sequence s_drv; ##[0:2] !oen; endsequence
   property p_idle; !cpu && per |-> mo && rtc == o32; endproperty
   a_idle: assert property (p_idle) else $error("idle pattern");
   property p_pdn; !per && rb |-> !cpu && sb && (!rtc || mo != o32); endproperty
   a_pdn: assert property (p_pdn) else $error("power-down pattern");
   property p_stby; !rb |-> sb && !mo && !per && rtc == o32; endproperty
   a_stby: assert property (p_stby) else $error("standby pattern");
   property p_bias; per |-> rb && sb; endproperty
   a_bias: assert property (p_bias) else $error("ram bias lost");
   property p_off; oen |-> !pin; endproperty
   a_off: assert property (p_off) else $error("pin active while released");
   property p_en; $rose(ck_q) |-> s_drv; endproperty
   a_en: assert property (p_en) else $error("pin not driven");
   property p_rd; i_rd && i_addr > 4'h4 |=> o_rdata == 16'h0000; endproperty
   a_rd: assert property (p_rd) else $error("unmapped read not zero");
   property p_quiet; !i_rd |=> o_rdata == 16'h0000; endproperty
   a_quiet: assert property (p_quiet) else $error("read data outside slot");
endmodule : pmc_chk

/* testbench/pin_sink.sv */
// Purpose: load on the clock output pin
// Assumes: released line is pulled low
// Notes: reports last high width and rise count
`timescale 1ns/100ps
module pin_sink (
   input wire logic i_clock, i_pin, i_oe_n,
   output int o_high, o_rises
);
   int run = 0;
   wire lvl = !i_oe_n && i_pin;
   initial {o_high, o_rises} = 64'h0;
   always @(posedge i_clock) begin
      run <= lvl ? run + 1 : 0;
      if (lvl && run == 0) o_rises <= o_rises + 1;
      if (!lvl && run != 0) o_high <= run;
   end
endmodule : pin_sink

/* testbench/test_power_mode_and_clock_output_control.sv */
// Purpose: self-checking bench of power mode and clock output
// Assumes: divider kept below 8 so periods stay short
// Notes: masked bits are left open by the mode table
`timescale 1ns/100ps
module test_power_mode_and_clock_output_control;
   logic i_clock = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000, o_rdata, r;
   logic [17:0] e;
   logic [31:0] s = 32'h12cc0686;
   logic o_clock_output_port_pin, o_clock_output_port_pin_oe_n;
   pwr_clk_pkg::pwr_ctrl_t o_ctrl;
   int err_total = 0, total_checks = 0, hi, rises, c, n;
   always #2.5 i_clock = ~i_clock;
   power_mode_and_clock_output_control u_power_mode_and_clock_output_control (.*);
   pin_sink u_pin_sink (.i_clock(i_clock), .i_pin(o_clock_output_port_pin),
      .i_oe_n(o_clock_output_port_pin_oe_n), .o_high(hi), .o_rises(rises));
   function automatic logic [31:0] xs(logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction : xs
   function automatic logic [17:0] ref_ctrl(int m, int o, logic w);
      logic a, b;
      a = o == 1;
      b = o == 2;
      case (m)
         0: return {9'h1fe, 9'h1ff};
         1: return {3'h3, o[0], o[0], 4'h6, 9'h1f6};
         2: return {2'h0, a, b, a | b, b, 2'h3, w, 5'h1f, a | b, 3'h7};
         default: return {3'h0, o[0], o[0], 4'h4, 9'h1f6};
      endcase
   endfunction : ref_ctrl
   task automatic chk(logic [15:0] g, logic [15:0] x);
      total_checks++;
      if (g !== x) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge i_clock);
      {i_wr, i_addr, i_wdata} <= {1'h1, a, d};
      @(posedge i_clock);
      i_wr <= 1'h0;
   endtask : wr
   task automatic rd(logic [3:0] a);
      @(posedge i_clock);
      {i_rd, i_addr} <= {1'h1, a};
      @(posedge i_clock);
      i_rd <= 1'h0;
      #1 r = o_rdata;
   endtask : rd
   task automatic summarize;
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   initial begin
      repeat (12) @(posedge i_clock);
      i_rst <= 1'h0;
      for (n = 0; n < 5; n++) begin
         rd(n[3:0]);
         chk(r, n == 4 ? 16'h01fe : 16'h0000);
      end
      wr(4'hf, s[15:0]);
      rd(4'hf);
      chk(r, 16'h0000);
      wr(4'h2, 16'h0005);
      rd(4'h2);
      chk(r, 16'h0005);
      for (n = 0; n < 16; n++) begin
         s = xs(s);
         wr(4'h0, {10'h000, s[0], 5'h00});
         wr(4'h3, {12'h000, n[3:0]});
         rd(4'h4);
         e = ref_ctrl(n % 4, n / 4, s[0]);
         chk(r & {7'h00, e[8:0]}, {7'h00, e[17:9] & e[8:0]});
      end
      wr(4'h3, 16'h0000);
      for (n = 0; n < 8; n++) begin
         s = xs(s);
         wr(4'h2, {13'h0000, s[2:0]});
         wr(4'h1, {5'h00, n[1], 10'h000});
         wr(4'h0, {9'h000, !n[2], 3'h0, n[0], 2'h0});
         repeat (3) @(posedge i_clock);
         c = rises;
         repeat (57) @(posedge i_clock);
         r = n[1:0] == 2'h3 ? {13'h0000, s[2:0]} + 16'h0001 : 16'h0001;
         if (n[2]) chk(16'(rises - c), 16'h0000);
         else chk(16'(hi), r);
      end
      summarize();
   end
   initial begin
      repeat (20000) @(posedge i_clock);
      err_total++;
      summarize();
   end
endmodule : test_power_mode_and_clock_output_control
bind power_mode_and_clock_output_control pmc_chk u_pmc_chk (.*);
